// File: gpt_pkg.sv
// ==================================================================
// Shared constants for the pulse, event and serial timing block
// ==================================================================
package gpt_pkg;
   // Clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_NS = 10;
   localparam int REF_HZ = 12_500_000;
   localparam int REF_NS = 80;
   localparam int TICK_CYC = CLK_HZ / REF_HZ;
   localparam int PPS_WIDTH_NS = 1000;
   localparam int PPS_WIDTH_CYC = PPS_WIDTH_NS / CLK_NS;
   localparam int TAG_RES_NS = 320;
   localparam int TAG_SHIFT = $clog2(TAG_RES_NS / REF_NS);
   localparam int BAUD_RESET = 9600;
   localparam int BAUD_DIV_RESET = CLK_HZ / BAUD_RESET;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CABLE = 8'h04;
   localparam logic [7:0] ADDR_UTC = 8'h08;
   localparam logic [7:0] ADDR_BAUD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_EVCNT = 8'h14;
   localparam logic [7:0] ADDR_EVTAG = 8'h18;

   // Control fields and reset values
   localparam int CTRL_PPS_EN = 0;
   localparam int CTRL_UTC = 1;
   localparam int CTRL_EV_RPT = 2;
   localparam int CTRL_ST_PPS = 4;
   localparam int CTRL_ST_EV = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
   localparam logic [23:0] CABLE_RESET = 24'h00_0000;
   localparam logic [23:0] UTC_RESET = 24'h00_0000;

   // Message layout: sync, kind, 16-bit count, 24-bit tag
   localparam int MSG_BYTES = 7;
   localparam logic [7:0] MSG_SYNC = 8'h10;
   localparam logic [7:0] MSG_TIME = 8'h01;
   localparam logic [7:0] MSG_STAT = 8'h02;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpt_pkg

// File: gpt_msg_tx.sv
`timescale 1ns/1ps
// ==================================================================
// Serial message sender: 8 data bits, odd parity, 1 stop bit
// ==================================================================
module gpt_msg_tx
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] baud_div,
   input wire logic start,
   input wire logic [8*gpt_pkg::MSG_BYTES-1:0] msg,
   output logic txd,
   output logic busy
);
   localparam int MW = 8 * gpt_pkg::MSG_BYTES;

   logic [MW-1:0] rest;
   logic [10:0] frame;
   logic [3:0] bits;
   logic [2:0] left;
   logic [15:0] cnt;

   // Frame builder: start, data lsb first, odd parity, stop
   function automatic logic [10:0] gpt_frame(input logic [7:0] b);
      gpt_frame = {1'b1, ~^b, b, 1'b0};
   endfunction : gpt_frame

   // Bit sequencer; divider restarts with each message so bits are full width
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         frame <= 11'h7FF;
         rest <= '0;
         bits <= 4'h0;
         left <= 3'h0;
         cnt <= 16'h0000;
         busy <= 1'b0;
      end
      else if (!busy && start)
      begin
         frame <= gpt_frame(msg[MW-1 -: 8]);
         rest <= msg << 8;
         left <= 3'(gpt_pkg::MSG_BYTES - 1);
         bits <= 4'hB;
         cnt <= 16'h0000;
         busy <= 1'b1;
      end
      else if (busy)
      begin
         if (cnt != baud_div - 16'h0001)
            cnt <= cnt + 16'h0001;
         else
         begin
            cnt <= 16'h0000;
            if (bits != 4'h1)
            begin
               frame <= {1'b1, frame[10:1]};
               bits <= bits - 4'h1;
            end
            else if (left != 3'h0)
            begin
               frame <= gpt_frame(rest[MW-1 -: 8]);
               rest <= rest << 8;
               left <= left - 3'h1;
               bits <= 4'hB;
            end
            else
            begin
               frame <= 11'h7FF;
               busy <= 1'b0;
            end
         end
      end
   end

   assign txd = frame[0];

   // Start bit goes out on the cycle after a message is accepted
   chk_start_bit: assert property (@(posedge clk) disable iff (reset)
      (start && !busy) |=> (!txd && busy))
      else $error("start bit not driven after message start");
   // Odd parity over the first data byte
   chk_odd_parity: assert property (@(posedge clk) disable iff (reset)
      (start && !busy) |=> ^frame[9:1])
      else $error("first frame does not carry odd parity");
endmodule : gpt_msg_tx

// File: gpt_timing.sv
`timescale 1ns/1ps
// Function
// - outputs start only once satellites qualify
// - status port sends periodic health messages
// - status port defaults 9600 8-odd-1, programmable
// - status port optionally carries selected timing messages
// - timing port transmit only, 8-odd-1 at the status port's rate (default 9600, programmable)
// - time message after each pulse and event
// - event counter counts, clears at reset, wraps
// - pulse messages count zero, event messages count
// - event messages enabled by output selection
// - pulse placed on 12.5 MHz ticks, 80 ns
// - one microsecond pulse once every second
// - pulse accurate only in overdetermined clock mode
// - reference position enables clock mode and monitor
// - signed cable offset, negative moves pulse earlier
// - UTC base corrects event time by fraction
// - events captured on rising input edge
// - event tag resolution 320 ns at input
// - pulse on reference tick nearest on-time mark
module gpt_timing
#(
   parameter int unsigned TICKS_PER_SEC = gpt_pkg::REF_HZ,
   parameter logic [15:0] BAUD_DIV_RESET = 16'(gpt_pkg::BAUD_DIV_RESET)
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic event_in,
   input wire logic sats_qualified,
   input wire logic ref_pos_valid,
   output logic pps_out,
   output logic pps_accurate,
   output logic satellite_integrity_monitor,
   output logic timing_txd,
   output logic status_txd
);
   localparam logic [23:0] TPS = 24'(TICKS_PER_SEC);
   localparam int MW = 8 * gpt_pkg::MSG_BYTES;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ==================================================================
   // Pin synchronisers and event edge
   // ==================================================================
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic ev_prev;
   logic running;
   logic od_mode;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         ev_prev <= 1'b0;
      end
      else
      begin
         sync1 <= {ref_pos_valid, sats_qualified, event_in};
         sync2 <= sync1;
         ev_prev <= sync2[0];
      end
   end

   logic ev_rise;
   assign ev_rise = sync2[0] && !ev_prev && running;

   // Operating mode; loss of satellites suspends output
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         running <= 1'b0;
         od_mode <= 1'b0;
         pps_accurate <= 1'b0;
         satellite_integrity_monitor <= 1'b0;
      end
      else
      begin
         running <= sync2[1];
         od_mode <= sync2[2] && sync2[1];
         satellite_integrity_monitor <= od_mode;
         pps_accurate <= od_mode;
      end
   end

   // ==================================================================
   // Registers
   // ==================================================================
   logic [31:0] ctrl;
   logic [23:0] cable_ofs;
   logic [23:0] utc_frac;
   logic [15:0] baud_div;
   logic [15:0] ev_count;
   logic [23:0] ev_tag;
   logic wr_fire;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] strb_q;

   function automatic logic [31:0] gpt_merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
      gpt_merge = old;
      for (int i = 0; i < 4; i++)
         if (s[i])
            gpt_merge[8*i +: 8] = d[8*i +: 8];
   endfunction : gpt_merge

   // Software-writable configuration, byte lanes honoured
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl <= gpt_pkg::CTRL_RESET;
         cable_ofs <= gpt_pkg::CABLE_RESET;
         utc_frac <= gpt_pkg::UTC_RESET;
         baud_div <= BAUD_DIV_RESET;
      end
      else if (wr_fire)
      begin
         unique case (aw_q)
            gpt_pkg::ADDR_CTRL: ctrl <= gpt_merge(ctrl, w_q, strb_q) & 32'h0000_0037;
            gpt_pkg::ADDR_CABLE: cable_ofs <= 24'(gpt_merge({8'h00, cable_ofs}, w_q, strb_q));
            gpt_pkg::ADDR_UTC: utc_frac <= 24'(gpt_merge({8'h00, utc_frac}, w_q, strb_q));
            gpt_pkg::ADDR_BAUD: baud_div <= 16'(gpt_merge({16'h0000, baud_div}, w_q, strb_q));
            default: ;
         endcase
      end
   end

   // ==================================================================
   // Reference tick and one-second frame
   // ==================================================================
   logic [2:0] tick_div;
   logic ref_tick;
   logic [23:0] tick_cnt;
   logic [23:0] pps_at;
   logic pps_fire;
   logic stat_fire;
   logic [6:0] pps_cnt;

   // 12.5 MHz ticks as enables; no second clock
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tick_div <= 3'h0;
         ref_tick <= 1'b0;
         tick_cnt <= 24'h00_0000;
      end
      else
      begin
         ref_tick <= (tick_div == 3'(gpt_pkg::TICK_CYC - 1));
         tick_div <= tick_div + 3'h1;
         if (ref_tick)
            tick_cnt <= (tick_cnt == TPS - 24'h00_0001) ? 24'h00_0000 : tick_cnt + 24'h00_0001;
      end
   end

   // Negative offset lands in the previous second, i.e. earlier
   assign pps_at = cable_ofs[23] ? TPS + cable_ofs : cable_ofs;

   assign pps_fire = ref_tick && (tick_cnt == pps_at) && running
      && ctrl[gpt_pkg::CTRL_PPS_EN];
   assign stat_fire = ref_tick && (tick_cnt == 24'h00_0000) && running;

   // Pulse shaper; only the leading edge carries time
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pps_out <= 1'b0;
         pps_cnt <= 7'h00;
      end
      else if (pps_fire)
      begin
         pps_out <= 1'b1;
         pps_cnt <= 7'(gpt_pkg::PPS_WIDTH_CYC - 1);
      end
      else if (pps_out)
      begin
         if (pps_cnt == 7'h00)
            pps_out <= 1'b0;
         else
            pps_cnt <= pps_cnt - 7'h01;
      end
   end

   sequence s_pps_body;
      ##99 pps_out ##1 !pps_out;
   endsequence

   chk_pps_width: assert property ($rose(pps_out) |-> s_pps_body)
      else $error("pulse width is not one microsecond");
   chk_pps_on_tick: assert property ($rose(pps_out) |->
      ($past(ref_tick) && $past(tick_cnt) == $past(pps_at)))
      else $error("pulse not on the offset reference tick");
   chk_no_output_idle: assert property (!running |=> !$rose(pps_out) && !$rose(pend_stat))
      else $error("output produced before satellites qualified");
   chk_accurate_mode: assert property (pps_accurate |-> $past(od_mode))
      else $error("accuracy flagged outside clock mode");
   chk_monitor_on: assert property (od_mode |=> satellite_integrity_monitor)
      else $error("integrity monitor not enabled in clock mode");

   // ==================================================================
   // Event capture
   // ==================================================================
   logic [24:0] tsum;
   logic [24:0] tadj;
   assign tsum = {1'b0, tick_cnt} + (ctrl[gpt_pkg::CTRL_UTC] ? {1'b0, utc_frac} : 25'h0);
   assign tadj = (tsum >= {1'b0, TPS}) ? tsum - {1'b0, TPS} : tsum;

   // Count wraps naturally past 65535; tag in 320 ns units
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ev_count <= 16'h0000;
         ev_tag <= 24'h00_0000;
      end
      else if (ev_rise)
      begin
         ev_count <= ev_count + 16'h0001;
         ev_tag <= 24'(tadj >> gpt_pkg::TAG_SHIFT);
      end
   end

   chk_event_step: assert property (ev_rise |=> ev_count == $past(ev_count) + 16'h0001)
      else $error("event counter did not advance by one");
   chk_count_hold: assert property (!ev_rise |=> $stable(ev_count))
      else $error("event counter moved without an event");
   chk_tag_gps: assert property ((ev_rise && !ctrl[gpt_pkg::CTRL_UTC]) |=>
      ev_tag == 24'($past(tick_cnt) >> gpt_pkg::TAG_SHIFT))
      else $error("event tag wrong in GPS time base");

   // ==================================================================
   // Message scheduling for both serial ports
   // ==================================================================
   logic pend_pps, pend_ev, pend_stat, pend_spps, pend_sev;
   logic tim_busy, st_busy;
   logic tim_start, take_pps, take_ev;
   logic st_start, take_stat, take_spps;
   logic [MW-1:0] tim_msg;
   logic [MW-1:0] st_msg;
   logic [MW-1:0] pps_msg;
   logic [MW-1:0] ev_msg;
   logic [7:0] health;

   assign health = {4'h0, ctrl[gpt_pkg::CTRL_PPS_EN], pps_accurate, od_mode, running};
   assign pps_msg = {gpt_pkg::MSG_SYNC, gpt_pkg::MSG_TIME, 16'h0000,
      24'(pps_at >> gpt_pkg::TAG_SHIFT)};
   assign ev_msg = {gpt_pkg::MSG_SYNC, gpt_pkg::MSG_TIME, ev_count, ev_tag};

   // Timing port: pulse message first, then a waiting event
   assign tim_start = !tim_busy && (pend_pps || pend_ev);
   assign take_pps = tim_start && pend_pps;
   assign take_ev = tim_start && !pend_pps && pend_ev;
   assign tim_msg = take_pps ? pps_msg : ev_msg;

   // Status port: health first, then selected timing copies
   assign st_start = !st_busy && (pend_stat || pend_spps || pend_sev);
   assign take_stat = st_start && pend_stat;
   assign take_spps = st_start && !pend_stat && pend_spps;
   always_comb
   begin
      if (take_stat)
         st_msg = {gpt_pkg::MSG_SYNC, gpt_pkg::MSG_STAT, 8'h00, health, 24'h00_0000};
      else if (take_spps)
         st_msg = pps_msg;
      else
         st_msg = ev_msg;
   end

   // Pending flags; a new event beats a same-cycle take.
   // One event slot is enough at the slow event rate.
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pend_pps <= 1'b0;
         pend_ev <= 1'b0;
         pend_stat <= 1'b0;
         pend_spps <= 1'b0;
         pend_sev <= 1'b0;
      end
      else
      begin
         pend_pps <= pps_fire || (pend_pps && !take_pps);
         pend_ev <= (ev_rise && ctrl[gpt_pkg::CTRL_EV_RPT])
            || (pend_ev && !take_ev);
         pend_stat <= stat_fire || (pend_stat && !take_stat);
         pend_spps <= (pps_fire && ctrl[gpt_pkg::CTRL_ST_PPS])
            || (pend_spps && !take_spps);
         pend_sev <= (ev_rise && ctrl[gpt_pkg::CTRL_ST_EV])
            || (pend_sev && !(st_start && !pend_stat && !pend_spps));
      end
   end

   chk_pps_queued: assert property (pps_fire |=> pend_pps)
      else $error("pulse message not queued");
   chk_msg_starts: assert property ((pend_pps && !tim_busy) |=> tim_busy)
      else $error("timing port did not start a waiting message");
   chk_pps_zero: assert property (take_pps |-> tim_msg[39:24] == 16'h0000)
      else $error("pulse message carries nonzero count");
   chk_event_gate: assert property ((ev_rise && !ctrl[gpt_pkg::CTRL_EV_RPT] && !pend_ev)
      |=> !pend_ev)
      else $error("event message queued while disabled");
   chk_status_beat: assert property (stat_fire |=> pend_stat)
      else $error("status message not queued at second boundary");

   // Timing port has no receive path at all
   gpt_msg_tx u_timing_tx (
      .clk(clk),
      .reset(reset),
      .baud_div(baud_div),
      .start(tim_start),
      .msg(tim_msg),
      .txd(timing_txd),
      .busy(tim_busy)
   );

   gpt_msg_tx u_status_tx (
      .clk(clk),
      .reset(reset),
      .baud_div(baud_div),
      .start(st_start),
      .msg(st_msg),
      .txd(status_txd),
      .busy(st_busy)
   );

   // ==================================================================
   // AXI4-Lite slave
   // ==================================================================
   logic aw_got, w_got;
   logic map_w, map_r;
   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign map_w = (aw_q <= gpt_pkg::ADDR_EVTAG) && (aw_q[1:0] == 2'h0);
   assign map_r = (s_axi_araddr <= gpt_pkg::ADDR_EVTAG) && (s_axi_araddr[1:0] == 2'h0);

   // Address and data taken in either order; response one cycle later
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_q <= 8'h00;
         w_q <= 32'h0000_0000;
         strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= gpt_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_got && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_q <= s_axi_wdata;
            strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!w_got && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (wr_fire)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= map_w ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read path; unmapped reads return zero with an error
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= gpt_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= map_r ? gpt_pkg::RESP_OKAY : gpt_pkg::RESP_SLVERR;
         unique case (s_axi_araddr)
            gpt_pkg::ADDR_CTRL: s_axi_rdata <= ctrl;
            gpt_pkg::ADDR_CABLE: s_axi_rdata <= {8'h00, cable_ofs};
            gpt_pkg::ADDR_UTC: s_axi_rdata <= {8'h00, utc_frac};
            gpt_pkg::ADDR_BAUD: s_axi_rdata <= {16'h0000, baud_div};
            gpt_pkg::ADDR_STATUS: s_axi_rdata <= {24'h00_0000, health};
            gpt_pkg::ADDR_EVCNT: s_axi_rdata <= {16'h0000, ev_count};
            gpt_pkg::ADDR_EVTAG: s_axi_rdata <= {8'h00, ev_tag};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end
endmodule : gpt_timing

// File: gpt_host_rx.sv
`timescale 1ns/1ps
// ==================================================================
// Host serial receiver: 8 data bits lsb first, odd parity, 1 stop
// ==================================================================
module gpt_host_rx
#(
   parameter int DIV = 4
)
(
   input wire logic clk,
   input wire logic rxd,
   output logic [7:0] data,
   output logic frame_ok,
   output logic got
);
   logic [9:0] sh;
   // Sample each bit in its middle; got stands one clock per byte
   initial
   begin
      got = 1'h0;
      data = 8'h00;
      frame_ok = 1'h0;
      forever
      begin
         @(negedge rxd);
         repeat (DIV / 2) @(posedge clk);
         for (int i = 0; i < 10; i++)
         begin
            repeat (DIV) @(posedge clk);
            sh[i] = rxd;
         end
         data <= sh[7:0];
         frame_ok <= ^sh[8:0] && sh[9];
         got <= 1'h1;
         @(posedge clk);
         got <= 1'h0;
      end
   end
endmodule : gpt_host_rx

// File: gps_pps_event_timing_tb.sv
`timescale 1ns/1ps
// ==================================================================
// Bench for the pulse, event and serial timing block
// ==================================================================
module gps_pps_event_timing_tb;
   localparam int TPS = 1500;
   localparam int DIV = 4;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic event_in = 1'h0, sats_qualified = 1'h0, ref_pos_valid = 1'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic pps_out, pps_accurate, satellite_integrity_monitor, timing_txd, status_txd;
   logic [7:0] t_dat, s_dat, tq[$], sq[$];
   logic t_ok, s_ok, t_got, s_got, pps_q = 1'h0;
   logic [15:0] rnd = 16'h0003;
   logic [23:0] km, km2;
   int fails = 0, check_count = 0, cyc = 0, rises = 0, t_rise = 0, hi = 0, wid = 0;
   int t0, t1, off;

   gpt_timing #(.TICKS_PER_SEC(TPS), .BAUD_DIV_RESET(16'(DIV))) i_dut (.clk, .reset,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .event_in, .sats_qualified, .ref_pos_valid, .pps_out,
      .pps_accurate, .satellite_integrity_monitor, .timing_txd, .status_txd);
   gpt_host_rx #(.DIV(DIV)) i_trx (.clk, .rxd(timing_txd), .data(t_dat), .frame_ok(t_ok),
      .got(t_got));
   gpt_host_rx #(.DIV(DIV)) i_srx (.clk, .rxd(status_txd), .data(s_dat), .frame_ok(s_ok),
      .got(s_got));

   // ==================================================================
   // Helpers
   // ==================================================================
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic int pps_gap(input int o);
      return (TPS + o) * gpt_pkg::TICK_CYC;
   endfunction : pps_gap

   task automatic results();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   // Write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : axr

   task automatic wait_pps(output int t);
      int n;
      n = rises;
      while (rises == n) @(posedge clk);
      t = t_rise;
   endtask : wait_pps

   task automatic fire();
      @(posedge clk);
      event_in <= 1'h1;
      idle(4);
      event_in <= 1'h0;
   endtask : fire

   // Seven bytes; returns kind and count, tag bytes dropped
   task automatic pop_msg(ref logic [7:0] q[$], output logic [23:0] k);
      while (q.size() < 7) @(negedge clk);
      cmp(q.pop_front(), gpt_pkg::MSG_SYNC);
      k[23:16] = q.pop_front();
      k[15:8] = q.pop_front();
      k[7:0] = q.pop_front();
      repeat (3) void'(q.pop_front());
   endtask : pop_msg

   // ==================================================================
   // Clock, watchdog, byte capture and pulse edges
   // ==================================================================
   initial
   begin
      forever #5 clk = ~clk;
   end

   // A hang costs one mismatch, then the closing report
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         fails++;
         results();
      end
   end

   // Sampled on the falling edge, clear of launch-edge updates
   always @(negedge clk)
   begin
      if (t_got === 1'h1)
      begin
         tq.push_back(t_dat);
         cmp(t_ok, 1);
      end
      if (s_got === 1'h1)
      begin
         sq.push_back(s_dat);
         cmp(s_ok, 1);
      end
      if (pps_out === 1'h1)
         hi++;
      else if (pps_q === 1'h1)
         wid = hi;
      if (pps_out === 1'h1 && pps_q === 1'h0)
      begin
         hi = 1;
         rises++;
         t_rise = cyc;
      end
      pps_q = pps_out;
   end

   // ==================================================================
   // Main sequence
   // ==================================================================
   initial
   begin
      idle(20);
      reset <= 1'h0;
      idle(2);
      axr(gpt_pkg::ADDR_CTRL, rd, rr);
      cmp(rd, gpt_pkg::CTRL_RESET);
      axr(8'h1C, rd, rr);
      cmp({rd, rr}, {32'h0, gpt_pkg::RESP_SLVERR});
      $display("test registers done");
      fire();
      idle(TPS * 9);
      cmp(rises + tq.size() + sq.size(), 0);
      $display("test no satellites done");
      sats_qualified <= 1'h1;
      wait_pps(t0);
      wait_pps(t1);
      cmp(t1 - t0, pps_gap(0));
      cmp(wid, gpt_pkg::PPS_WIDTH_CYC);
      for (int i = 0; i < 2; i++)
      begin
         pop_msg(tq, km);
         cmp(km, {gpt_pkg::MSG_TIME, 16'h0000});
         pop_msg(sq, km);
         cmp(km, {gpt_pkg::MSG_STAT, 16'h0009});
      end
      $display("test pulse done");
      for (int i = 1; i <= 3; i++)
      begin
         rnd = lfsr(rnd);
         idle(1200 + int'(rnd[8:0]));
         fire();
         pop_msg(tq, km);
         cmp(km, {gpt_pkg::MSG_TIME, 16'(i)});
      end
      axw(gpt_pkg::ADDR_CTRL, 32'h1);
      idle(1200);
      fire();
      idle(600);
      cmp(tq.size(), 0);
      axr(gpt_pkg::ADDR_EVCNT, rd, rr);
      cmp(rd, 4);
      $display("test events done");
      ref_pos_valid <= 1'h1;
      idle(8);
      cmp({pps_accurate, satellite_integrity_monitor}, 2'h3);
      wait_pps(t0);
      idle(400);
      sq.delete();
      rnd = lfsr(rnd);
      off = -1 - int'(rnd[6:0]);
      axw(gpt_pkg::ADDR_CTRL, 32'h13);
      axw(gpt_pkg::ADDR_CABLE, 32'(off));
      wait_pps(t1);
      cmp(t1 - t0, pps_gap(off));
      idle(1500);
      pop_msg(sq, km);
      pop_msg(sq, km2);
      cmp(km[23:16] + km2[23:16], 3);
      $display("test offset and status port done");
      results();
   end
endmodule : gps_pps_event_timing_tb
